// ==== core/acc_conv_ctrl.v ====
// converter control: wishbone registers, start/busy sequencing,
// conversion clock divider, pin routing and result registers.
// assumes an external sar core delivering a 12-bit code on SAR_DATA
// when the sixteenth conversion clock tick ends the cycle.
//
// Summary of operation
// - ref select: supply or external pin
// - divider codes 0..6 give fsys/2^n
// - pin enables make analog inputs, reset ones
// - analog pin drops its pull-high
// - analog pin overrides port direction
// - start rise then fall begins conversion
// - start held high resets converter, busy one
// - busy clears when conversion finishes
// - end of conversion sets interrupt flag
// - interrupt needs global and converter enable
// - conversion lasts sixteen conversion clocks
// - converter powered only while power-off clear
// - result is 12-bit unsigned code
// - justify bit selects left or right alignment
// - channel select, internal reference override
// - busy read-only, resets to one
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_conv_ctrl #(
  parameter NPIN = 5
) (
  input  wire        SYS_CLK,    // system clock 100 MHz
  input  wire        RSTN,       // async reset, active low
  input  wire        WB_CYC_I,   // bus cycle
  input  wire        WB_STB_I,   // strobe
  input  wire        WB_WE_I,    // write enable
  input  wire [7:0]  WB_ADR_I,   // byte address
  input  wire [3:0]  WB_SEL_I,   // byte selects
  input  wire [31:0] WB_DAT_I,   // write data
  output reg  [31:0] WB_DAT_O,   // read data
  output reg         WB_ACK_O,   // acknowledge
  input  wire [11:0] SAR_DATA,   // code from sar core
  input  wire [NPIN-1:0] PULLUP_CFG, // software pull-high setting
  input  wire [NPIN-1:0] PORT_DIR,   // port direction, 1 = input
  output reg         SAR_RESET,  // converter held in reset
  output reg         SAR_RUN,    // conversion in progress
  output reg         SAR_CLK_TICK, // conversion clock tick
  output reg         SAR_POWER,  // analog core powered
  output reg         REF_EXT,    // 1 = external reference pin
  output reg         REF_PIN_OTHER_EN, // other functions on ref pin
  output reg         BANDGAP_EN, // bandgap enable
  output reg  [2:0]  MUX_SEL,    // input 0..4
  output reg         MUX_IREF,   // internal 1.25 V routed
  output reg  [NPIN-1:0] ANALOG_EN,  // pin is analog input
  output reg  [NPIN-1:0] PULLUP_EN,  // effective pull-high
  output reg  [NPIN-1:0] PORT_DIR_EFF, // effective direction
  output reg         CONV_IRQ    // converter interrupt
);
  reg         start_q;
  reg         poff_q;
  reg         just_q;
  reg  [2:0]  chan_q;
  reg  [7:0]  ctrl1_q;
  reg  [NPIN-1:0] pinen_q;
  reg         gie_q;
  reg         cie_q;
  reg         flag_q;
  reg         busy_q;
  reg         run_q;
  reg  [5:0]  div_cnt_q;
  reg  [4:0]  tick_cnt_q;
  reg  [11:0] res_q;
  wire        acc_wr;
  wire        acc_rd;
  wire        tick;
  wire        done;
  wire        start_fall;
  wire        start_rise;
  wire [2:0]  div_sel;
  wire [5:0]  div_max;
  reg  [31:0] rd_d;
  wire [15:0] res_w;

  // register map, byte offsets on the bus
  //   0x00 ctrl0: bit7 start, bit6 busy (read-only), bit5 power-off,
  //        bit4 justify, bit3 reads zero, bits2:0 channel
  //   0x04 ctrl1: bit7 internal source, bit6 bandgap, bit5 zero,
  //        bit4 reference select, bit3 zero, bits2:0 divider code
  //   0x08 pin enables, bits4:0, all ones after reset
  //   0x0C result low byte, read-only
  //   0x10 result high byte, read-only
  //   0x14 interrupt enables: bit1 global, bit0 converter
  //   0x18 completion flag: bit0, write one to clear
  //   other offsets read zero, writes there are ignored
  //
  // conversion sequence as software sees it
  //   write start high: converter reset, busy forced high
  //   write start low with power-off clear: run begins
  //   each conversion clock spans 2^code system clocks
  //   sixteenth tick ends the run: result, busy clear, flag
  //   power-off during a run: run dropped, busy stays high
  //   divider code seven: run held, no ticks issued
  //
  // hazards and limits
  //   start left high keeps the converter in reset
  //   flag set and software clear in one cycle: set wins
  //   both result bytes come from one register, torn if a run ends between the two reads
  //   busy reads high after reset until a run completes
  //   divider range is not policed: software picks the code
  //   busy and result registers ignore bus writes

  assign acc_wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
  assign acc_rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O;
  assign start_rise = acc_wr && WB_ADR_I == `ACC_OFS_CTRL0 &&
                      WB_DAT_I[`ACC_B_START] && !start_q;
  assign start_fall = acc_wr && WB_ADR_I == `ACC_OFS_CTRL0 &&
                      !WB_DAT_I[`ACC_B_START] && start_q;
  assign div_sel = ctrl1_q[2:0];
  // divide ratio minus one, 2^code - 1
  assign div_max = (6'h01 << div_sel) - 6'h01;
  assign tick = run_q && !poff_q && div_sel != `ACC_DIV_STOP &&
                div_cnt_q == div_max;
  assign done = tick && tick_cnt_q == `ACC_CONV_CYCLES - 5'h01;

  // register writes and sequencing state
  // writes land at the edge that takes the request,
  // the same edge that raises the acknowledge
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      start_q <= 1'b0;
      poff_q  <= 1'b1;
      just_q  <= 1'b0;
      chan_q  <= 3'h0;
      ctrl1_q <= `ACC_CTRL1_RST;
      pinen_q <= `ACC_PINEN_RST;
      gie_q   <= 1'b0;
      cie_q   <= 1'b0;
      flag_q  <= 1'b0;
    end
    else
    begin
      if (acc_wr)
      begin
        case (WB_ADR_I)
          `ACC_OFS_CTRL0:
          begin
            start_q <= WB_DAT_I[`ACC_B_START];
            poff_q  <= WB_DAT_I[`ACC_B_POFF];
            just_q  <= WB_DAT_I[`ACC_B_JUST];
            chan_q  <= WB_DAT_I[2:0];
          end
          `ACC_OFS_CTRL1: ctrl1_q <= WB_DAT_I[7:0] & 8'hD7;
          `ACC_OFS_PINEN: pinen_q <= WB_DAT_I[NPIN-1:0];
          `ACC_OFS_INTEN:
          begin
            gie_q <= WB_DAT_I[`ACC_B_GIE];
            cie_q <= WB_DAT_I[`ACC_B_CIE];
          end
          default: ;
        endcase
      end
      // set wins over software clear (write 1 to clear)
      if (done)
        flag_q <= 1'b1;
      else if (acc_wr && WB_ADR_I == `ACC_OFS_INTFLG && WB_DAT_I[0])
        flag_q <= 1'b0;
    end
  end

  // busy, run and conversion clock counters
  // start or power-off holds every counter at zero, so a new
  // run always begins with a full first conversion clock;
  // the run ends 16 * 2^code cycles after the start-low edge
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      busy_q     <= 1'b1;
      run_q      <= 1'b0;
      div_cnt_q  <= 6'h00;
      tick_cnt_q <= 5'h00;
      res_q      <= 12'h000;
    end
    else if (start_rise || start_q || poff_q)
    begin
      // start high: converter reset, busy forced; power-off aborts
      if (start_rise || start_q)
        busy_q <= 1'b1;
      // power-off written with the start fall keeps the run off
      run_q      <= start_fall && !WB_DAT_I[`ACC_B_POFF];
      div_cnt_q  <= 6'h00;
      tick_cnt_q <= 5'h00;
    end
    else if (run_q)
    begin
      if (div_sel == `ACC_DIV_STOP || div_cnt_q == div_max)
        div_cnt_q <= 6'h00;
      else
        div_cnt_q <= div_cnt_q + 6'h01;
      if (tick)
        tick_cnt_q <= tick_cnt_q + 5'h01;
      if (done)
      begin
        run_q  <= 1'b0;
        busy_q <= 1'b0;
        res_q  <= SAR_DATA;
      end
    end
  end

  // result bytes in the selected alignment
  assign res_w = just_q ? {4'h0, res_q} : {res_q, 4'h0};

  // read mux
  // unimplemented bits and unmapped offsets read zero
  always @*
  begin
    rd_d = 32'h00000000;
    case (WB_ADR_I)
      `ACC_OFS_CTRL0:  rd_d = {24'h000000, start_q, busy_q, poff_q,
                               just_q, 1'b0, chan_q};
      `ACC_OFS_CTRL1:  rd_d = {24'h000000, ctrl1_q};
      `ACC_OFS_PINEN:  rd_d = {{(32-NPIN){1'b0}}, pinen_q};
      `ACC_OFS_RES_LO: rd_d = {24'h000000, res_w[7:0]};
      `ACC_OFS_RES_HI: rd_d = {24'h000000, res_w[15:8]};
      `ACC_OFS_INTEN:  rd_d = {30'h00000000, gie_q, cie_q};
      `ACC_OFS_INTFLG: rd_d = {31'h00000000, flag_q};
      default:         rd_d = 32'h00000000;
    endcase
  end

  // bus answer one cycle after request
  // ack is a one-cycle pulse; read data stays until next read
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
      if (acc_rd)
        WB_DAT_O <= rd_d;
    end
  end

  // registered analog-side outputs
  // each follows its state one cycle late; run is masked by
  // reset and power-off so the core never sees run together
  // with reset or with power removed
  // pins enabled as analog drop pull-high and read as inputs
  // internal source routed: every pin disconnected
  // ref pin shared functions off while external ref chosen
  always @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SAR_RESET        <= 1'b1;
      SAR_RUN          <= 1'b0;
      SAR_CLK_TICK     <= 1'b0;
      SAR_POWER        <= 1'b0;
      REF_EXT          <= 1'b0;
      REF_PIN_OTHER_EN <= 1'b1;
      BANDGAP_EN       <= 1'b0;
      MUX_SEL          <= 3'h0;
      MUX_IREF         <= 1'b0;
      ANALOG_EN        <= {NPIN{1'b0}};
      PULLUP_EN        <= {NPIN{1'b0}};
      PORT_DIR_EFF     <= {NPIN{1'b0}};
      CONV_IRQ         <= 1'b0;
    end
    else
    begin
      SAR_RESET        <= start_q || poff_q;
      SAR_RUN          <= run_q && !start_q && !poff_q;
      SAR_CLK_TICK     <= tick;
      SAR_POWER        <= !poff_q;
      REF_EXT          <= ctrl1_q[`ACC_B_REFS];
      REF_PIN_OTHER_EN <= !ctrl1_q[`ACC_B_REFS];
      BANDGAP_EN       <= ctrl1_q[`ACC_B_BGEN];
      MUX_SEL          <= chan_q[2] ? 3'h4 : chan_q;
      MUX_IREF         <= ctrl1_q[`ACC_B_IREF];
      ANALOG_EN        <= ctrl1_q[`ACC_B_IREF] ? {NPIN{1'b0}} : pinen_q;
      PULLUP_EN        <= PULLUP_CFG & ~pinen_q;
      PORT_DIR_EFF     <= PORT_DIR | pinen_q;
      CONV_IRQ         <= flag_q & gie_q & cie_q;
    end
  end
endmodule

// ==== core/acc_defs.vh ====
// register offsets, field positions, reset values and timing counts
// for the converter control block; included by the design file
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_OFS_CTRL0     8'h00
`define ACC_OFS_CTRL1     8'h04
`define ACC_OFS_PINEN     8'h08
`define ACC_OFS_RES_LO    8'h0C
`define ACC_OFS_RES_HI    8'h10
`define ACC_OFS_INTEN     8'h14
`define ACC_OFS_INTFLG    8'h18
`define ACC_B_START       7
`define ACC_B_BUSY        6
`define ACC_B_POFF        5
`define ACC_B_JUST        4
`define ACC_B_IREF        7
`define ACC_B_BGEN        6
`define ACC_B_REFS        4
`define ACC_B_GIE         1
`define ACC_B_CIE         0
`define ACC_CTRL1_RST     8'h00
`define ACC_PINEN_RST     5'h1F
`define ACC_CONV_CYCLES   5'h10
`define ACC_DIV_STOP      3'h7
`endif

// ==== tb/acc_conv_ctrl_sva.sv ====
// port-level assertions for the converter control block
// bound into every acc_conv_ctrl instance, watches its ports only
`timescale 1ns/1ps
module acc_conv_ctrl_sva #(
  parameter NPIN = 5
) (
  input wire logic            SYS_CLK,          // clock
  input wire logic            RSTN,             // reset, active low
  input wire logic            WB_CYC_I,         // bus cycle
  input wire logic            WB_STB_I,         // strobe
  input wire logic            WB_ACK_O,         // acknowledge
  input wire logic            SAR_RESET,        // converter reset
  input wire logic            SAR_RUN,          // conversion running
  input wire logic            SAR_POWER,        // analog power
  input wire logic            REF_EXT,          // external reference
  input wire logic            REF_PIN_OTHER_EN, // ref pin shared use
  input wire logic [2:0]      MUX_SEL,          // input select
  input wire logic            MUX_IREF,         // internal source
  input wire logic [NPIN-1:0] ANALOG_EN,        // analog pins
  input wire logic [NPIN-1:0] PULLUP_EN,        // pull-high
  input wire logic [NPIN-1:0] PORT_DIR_EFF      // direction
);
  // one clock domain, reset disables all checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_REF_PIN: assert property (REF_PIN_OTHER_EN == !REF_EXT)
    else $error("ref pin shared use not opposite to ref select");
  AST_PULL_OFF: assert property (!MUX_IREF |->
    (PULLUP_EN & ANALOG_EN) == '0) else $error("pull-high on analog pin");
  AST_DIR_OVR: assert property (!MUX_IREF |->
    (ANALOG_EN & ~PORT_DIR_EFF) == '0) else $error("analog pin not input");
  AST_IREF_PINS: assert property (MUX_IREF |-> ANALOG_EN == '0)
    else $error("pins connected while internal source routed");
  AST_MUX_RANGE: assert property (MUX_SEL <= 3'h4)
    else $error("input select out of range");
  AST_RUN_RST: assert property (SAR_RUN |-> SAR_POWER && !SAR_RESET)
    else $error("run while converter reset or unpowered");
  AST_ABORT: assert property ($fell(SAR_POWER) |-> !SAR_RUN)
    else $error("run survives power-off");
endmodule

bind acc_conv_ctrl acc_conv_ctrl_sva #(.NPIN(NPIN)) u_sva (.SYS_CLK, .RSTN,
  .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .SAR_RESET, .SAR_RUN, .SAR_POWER,
  .REF_EXT, .REF_PIN_OTHER_EN, .MUX_SEL, .MUX_IREF, .ANALOG_EN,
  .PULLUP_EN, .PORT_DIR_EFF);

// ==== tb/acc_conv_ctrl_tb_top.sv ====
// self-checking bench for the converter control block
// drives wishbone and sar code; reads are checked from a queue
`timescale 1ns/1ps
`include "acc_defs.vh"
`define CHK(n,e,a) begin n_tests++; if ((e) !== (a)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module acc_conv_ctrl_tb_top;
  logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic        ack, run, irq, rext;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, hi, lo;
  logic [11:0] sar = 12'h000;
  logic [4:0]  pcfg = 5'h00, pdir = 5'h00;
  logic [15:0] rnd = 16'h28B7;
  logic [2:0]  mux;
  logic [63:0] eq[$], nt;
  logic        tck, srst, spwr, rpo, bgen, iref;
  logic [4:0]  aen, pull, pdeff;
  int          err_count = 0, n_tests = 0, k, t = 0;

  acc_conv_ctrl dut (.SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SAR_DATA(sar),
    .PULLUP_CFG(pcfg), .PORT_DIR(pdir), .SAR_RESET(srst), .SAR_RUN(run),
    .SAR_CLK_TICK(tck), .SAR_POWER(spwr), .REF_EXT(rext),
    .REF_PIN_OTHER_EN(rpo), .BANDGAP_EN(bgen), .MUX_SEL(mux),
    .MUX_IREF(iref), .ANALOG_EN(aen), .PULLUP_EN(pull),
    .PORT_DIR_EFF(pdeff), .CONV_IRQ(irq));

  // conversion clock ticks seen on the pin
  always @(posedge clk)
    if (tck === 1'b1)
      t++;

  // 100 mhz clock
  always #5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // verdict and end of run
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one classic cycle; a read notes expected value and mask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w)
      eq.push_back({m, d});
    do @(posedge clk); while (ack !== 1'b1 && ++i < 50);
    if (ack !== 1'b1)
      err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // read answers against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
    begin
      nt = eq.pop_front();
      `CHK("rdata", nt[31:0] & nt[63:32], rdat & nt[63:32])
    end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, `ACC_OFS_CTRL0, 32'h60);
    bus(1, `ACC_OFS_PINEN, 32'hFF);
    bus(0, `ACC_OFS_PINEN, 32'h1F);
    bus(1, `ACC_OFS_CTRL1, 32'hF8);
    bus(0, `ACC_OFS_CTRL1, 32'hD0);
    `CHK("ref_ext", 1'b1, rext)
    `CHK("ref_other", 1'b0, rpo)
    `CHK("bandgap", 1'b1, bgen)
    `CHK("iref", 1'b1, iref)
    `CHK("iref_pins", 5'h00, aen)
    bus(0, 8'hFC, 32'h0);
    for (int dv = 0; dv < 7; dv++)
    begin
      rnd = lfsr(rnd);
      sar <= rnd[11:0];
      pcfg <= rnd[15:11];
      pdir <= rnd[4:0];
      bus(1, `ACC_OFS_CTRL1, {29'h0, dv[2:0]});
      bus(1, `ACC_OFS_INTEN, {30'h0, dv[1:0]});
      bus(1, `ACC_OFS_PINEN, {27'h0, rnd[9:5]});
      bus(1, `ACC_OFS_CTRL0, {29'h10, dv[2:0]});
      bus(0, `ACC_OFS_CTRL0, 32'h40, 32'h40);
      `CHK("sar_reset", 1'b1, srst)
      t = 0;
      bus(1, `ACC_OFS_CTRL0, {27'h0, dv[0], 1'b0, dv[2:0]});
      k = 0;
      while (run === 1'b1 && k < 2000)
      begin
        @(posedge clk);
        k++;
      end
      `CHK("cycles", 16 << dv, k)
      `CHK("irq", dv[1:0] == 2'h3, irq)
      `CHK("mux", (dv > 3) ? 3'h4 : dv[2:0], mux)
      `CHK("ticks", 16, t)
      `CHK("analog_en", rnd[9:5], aen)
      `CHK("pullup", pcfg & ~rnd[9:5], pull)
      `CHK("dir", pdir | rnd[9:5], pdeff)
      `CHK("power", 1'b1, spwr)
      hi = dv[0] ? {28'h0, rnd[11:8]} : {24'h0, rnd[11:4]};
      lo = dv[0] ? {24'h0, rnd[7:0]} : {24'h0, rnd[3:0], 4'h0};
      bus(0, `ACC_OFS_RES_HI, hi);
      bus(0, `ACC_OFS_RES_LO, lo);
      bus(0, `ACC_OFS_CTRL0, 32'h00, 32'h40);
      bus(0, `ACC_OFS_INTFLG, 32'h1, 32'h1);
      bus(1, `ACC_OFS_INTFLG, 32'h1);
    end
    // power-off in mid conversion, conversion clock 640 ns
    bus(1, `ACC_OFS_INTEN, 32'h3);
    bus(1, `ACC_OFS_CTRL0, 32'h80);
    bus(1, `ACC_OFS_CTRL0, 32'h00);
    sar <= ~sar;
    repeat (100) @(posedge clk);
    bus(1, `ACC_OFS_CTRL0, 32'h20);
    repeat (1100) @(posedge clk);
    bus(0, `ACC_OFS_CTRL0, 32'h60);
    bus(0, `ACC_OFS_RES_HI, hi);
    bus(0, `ACC_OFS_INTFLG, 32'h0);
    `CHK("irq", 1'b0, irq)
    `CHK("power", 1'b0, spwr)
    // undefined divider freezes the run
    bus(1, `ACC_OFS_CTRL1, 32'h7);
    bus(1, `ACC_OFS_CTRL0, 32'h80);
    bus(1, `ACC_OFS_CTRL0, 32'h00);
    repeat (300) @(posedge clk);
    bus(0, `ACC_OFS_CTRL0, 32'h40, 32'h40);
    `CHK("run", 1'b1, run)
    wrap_up;
  end
endmodule
